/* File: logic/serial_config_register_port.sv */
// serial_config_register_port: write-only serial configuration port and its registers
// assumes: serial pins asynchronous to ref_clk (serial clock well below ref_clk/4);
// extended_mode and power_down are static straps from the pins
`timescale 1ns/1ps
module serial_config_register_port (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic extended_mode,
  input wire logic power_down,
  input wire logic serial_clock,
  input wire logic serial_select_n,
  input wire logic serial_input_line,
  input wire logic pin_single_rate,
  input wire logic edge_select_pin,
  output logic reset_input_differential,
  output logic termination_trim_skip,
  output logic duty_stabilizer_on,
  output logic double_rate_strobe_phase,
  output logic single_rate_select,
  output logic output_edge_rising,
  output logic [8:0] offset_value,
  output logic offset_negative,
  output logic [8:0] full_scale_adjust,
  output logic [8:0] phase_fine,
  output logic phase_adjust_on,
  output logic [3:0] phase_coarse,
  output logic low_freq_clock,
  output logic [1:0] buffer_size,
  output logic auto_stop_write,
  output logic two_port_enable,
  output logic test_pattern_on
);
  logic rst_meta; // reset release stage one
  logic rst_n; // synchronised reset
  logic clk_rise; // one cycle per serial clock rising edge
  logic sel_n_sync;
  logic data_sync;
  logic mode_sync;
  logic frame_done;
  logic [3:0] frame_addr;
  logic [15:0] frame_data;
  logic [15:0] cfg_reg;
  logic [15:0] offset_reg;
  logic [15:0] full_scale_reg;
  logic [15:0] fine_reg;
  logic [15:0] coarse_reg;
  logic [15:0] capture_reg;
  logic use_regs;

  // reset asserts at once and releases through two flops
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // serial clock sampled as an ordinary pin, its rising edge found in ref_clk
  pin_sync #(.RESET_VALUE(1'b0)) clk_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .pin(serial_clock),
    .level(),
    .rise(clk_rise) // [R3]
  );

  // select idles high so a reset never looks like an open frame
  pin_sync #(.RESET_VALUE(1'b1)) sel_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .pin(serial_select_n),
    .level(sel_n_sync),
    .rise()
  );

  // data and mode share the same two-stage delay as the clock, keeping setup aligned
  pin_sync #(.RESET_VALUE(1'b0)) dat_sync (
    .clk(ref_clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .pin(serial_input_line),
    .level(data_sync),
    .rise()
  );

  pin_sync #(.RESET_VALUE(1'b0)) mode_sync_i (
    .clk(ref_clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .pin(extended_mode),
    .level(mode_sync),
    .rise()
  );

  // frame assembly; the port is dead outside extended mode
  frame_shifter #(.FRAME_BITS(serial_config_pkg::FRAME_BITS)) shifter (
    .clk(ref_clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .enable(mode_sync), // [R1]
    .select_n(sel_n_sync),
    .bit_strobe(clk_rise),
    .bit_value(data_sync),
    .frame_done(frame_done),
    .frame_addr(frame_addr),
    .frame_data(frame_data)
  );

  // address decode; reserved addresses match nothing and are dropped
  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    hit = (a == target);
  endfunction

  // register bank; power_down is deliberately not used so contents survive it [R13]
  // there is no read path at all, the bank is write-only [R8]
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg <= serial_config_pkg::CONFIG_RESET; // [R14] [R15] [R16] [R17] [R18] [R19]
      offset_reg <= serial_config_pkg::OFFSET_RESET;
      full_scale_reg <= serial_config_pkg::FULL_SCALE_RESET;
      fine_reg <= serial_config_pkg::PHASE_FINE_RESET;
      coarse_reg <= serial_config_pkg::PHASE_COARSE_RESET;
      capture_reg <= serial_config_pkg::CAPTURE_RESET; // [R21]
    end
    else if (clk_en && frame_done)
    begin
      if (hit(frame_addr, serial_config_pkg::ADDR_CONFIG)) // [R11]
      begin
        cfg_reg <= frame_data;
      end
      if (hit(frame_addr, serial_config_pkg::ADDR_OFFSET)) // [R11]
      begin
        offset_reg <= frame_data;
      end
      if (hit(frame_addr, serial_config_pkg::ADDR_FULL_SCALE)) // [R11]
      begin
        full_scale_reg <= frame_data;
      end
      if (hit(frame_addr, serial_config_pkg::ADDR_PHASE_FINE)) // [R11]
      begin
        fine_reg <= frame_data;
      end
      if (hit(frame_addr, serial_config_pkg::ADDR_PHASE_COARSE)) // [R11]
      begin
        coarse_reg <= frame_data;
      end
      if (hit(frame_addr, serial_config_pkg::ADDR_CAPTURE)) // [R11]
      begin
        capture_reg <= frame_data;
      end
    end
  end

  // in normal mode the fields fall back to pin settings or fixed defaults [R12]
  assign use_regs = mode_sync;
  assign reset_input_differential = use_regs & cfg_reg[serial_config_pkg::BIT_RESET_DIFF]; // [R14]
  assign termination_trim_skip = use_regs & cfg_reg[serial_config_pkg::BIT_TRIM_SKIP]; // [R15]
  assign duty_stabilizer_on = use_regs ? cfg_reg[serial_config_pkg::BIT_DUTY_ON] : 1'b1; // [R16]
  // strobe phase matters only in double rate; normal mode is fixed at zero phase [R17]
  assign double_rate_strobe_phase = use_regs & cfg_reg[serial_config_pkg::BIT_STROBE_PHASE] & ~single_rate_select;
  assign single_rate_select = use_regs ? cfg_reg[serial_config_pkg::BIT_SINGLE_RATE] : pin_single_rate; // [R18]
  // edge choice has meaning only in single rate [R19]
  assign output_edge_rising = single_rate_select &
    (use_regs ? cfg_reg[serial_config_pkg::BIT_EDGE_SELECT] : edge_select_pin);
  assign offset_value = use_regs ? {1'b0, offset_reg[15:8]} : 9'h000;
  assign offset_negative = use_regs & offset_reg[7];
  assign full_scale_adjust = use_regs ? full_scale_reg[15:7] : serial_config_pkg::FULL_SCALE_RESET[15:7];
  assign phase_fine = use_regs ? fine_reg[15:7] : 9'h000;
  assign phase_adjust_on = use_regs & coarse_reg[serial_config_pkg::BIT_PHASE_ON];
  assign phase_coarse = use_regs ? coarse_reg[14:11] : 4'h0;
  assign low_freq_clock = use_regs & coarse_reg[10];
  // capture defaults hold in normal mode as well [R21]
  assign buffer_size = use_regs ? capture_reg[serial_config_pkg::BIT_BSIZE_HI:serial_config_pkg::BIT_BSIZE_LO]
    : serial_config_pkg::CAPTURE_RESET[15:14];
  assign auto_stop_write = use_regs ? capture_reg[serial_config_pkg::BIT_AUTO_STOP] : 1'b1;
  assign two_port_enable = use_regs & capture_reg[serial_config_pkg::BIT_TWO_PORT];
  assign test_pattern_on = use_regs & capture_reg[serial_config_pkg::BIT_TEST_PATTERN];
endmodule

/* File: inc/serial_config_pkg.sv */
// serial_config_pkg: constants for the three-wire write-only configuration port
// assumes: used by serial_config_register_port, its frame_shifter submodule and the testbench
// Operation
// R1 - writes accepted only in extended control mode
// R2 - controller holds select low whole access
// R3 - sample data on serial clock rising edge
// R4 - frame is 32 bits, msb first
// R5 - 12-bit header, 4 address, 16 data bits
// R6 - address bit three first, bit zero last
// R7 - next frame may start at 33rd clock
// R8 - registers are write-only, no readback
// R9 - controller writes all six registers first
// R10 - controller avoids writes during calibration
// R11 - decode 1h,2h,3h,Dh,Eh,Fh; others reserved
// R12 - registers ignored in normal control mode
// R13 - contents kept through power-down
// R14 - bit 14 selects differential reset input
// R15 - bit 13 skips termination trim
// R16 - bit 12 enables duty stabilizer
// R17 - bit 11 sets double-rate strobe phase
// R18 - bit 10 selects single data rate
// R19 - bit 8 selects rising output edge
// R20 - controller writes ones to fixed bits
// R21 - buffer defaults: 4K, autostop, port one, no pattern
// R22 - drop short or bad-header frames
package serial_config_pkg;
  localparam int FRAME_BITS = 32;
  localparam int HEADER_BITS = 12;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 16;
  localparam logic [11:0] FRAME_HEADER = 12'h001;
  localparam logic [5:0] COUNT_LAST = 6'h1F;
  // register addresses
  localparam logic [3:0] ADDR_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_OFFSET = 4'h2;
  localparam logic [3:0] ADDR_FULL_SCALE = 4'h3;
  localparam logic [3:0] ADDR_PHASE_FINE = 4'hD;
  localparam logic [3:0] ADDR_PHASE_COARSE = 4'hE;
  localparam logic [3:0] ADDR_CAPTURE = 4'hF;
  // power-on values
  // fixed ones, single-ended reset input, trim on, stabilizer on, 90 degree phase, single rate, falling edge
  localparam logic [15:0] CONFIG_RESET = 16'h9EFF;
  localparam logic [15:0] OFFSET_RESET = 16'h007F;
  localparam logic [15:0] FULL_SCALE_RESET = 16'h807F;
  localparam logic [15:0] PHASE_FINE_RESET = 16'h007F;
  localparam logic [15:0] PHASE_COARSE_RESET = 16'h03FF;
  localparam logic [15:0] CAPTURE_RESET = 16'hA7FF;
  // configuration field positions
  localparam int BIT_RESET_DIFF = 14;
  localparam int BIT_TRIM_SKIP = 13;
  localparam int BIT_DUTY_ON = 12;
  localparam int BIT_STROBE_PHASE = 11;
  localparam int BIT_SINGLE_RATE = 10;
  localparam int BIT_EDGE_SELECT = 8;
  // capture-buffer field positions, then the coarse-phase register's enable bit
  localparam int BIT_BSIZE_HI = 15;
  localparam int BIT_BSIZE_LO = 14;
  localparam int BIT_AUTO_STOP = 13;
  localparam int BIT_TWO_PORT = 12;
  localparam int BIT_TEST_PATTERN = 11;
  localparam int BIT_PHASE_ON = 15;
endpackage

/* File: logic/pin_sync.sv */
// pin_sync: two-flop synchroniser plus rising-edge detector for one pin
// assumes: pin is asynchronous to clk
`timescale 1ns/1ps
module pin_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pin,
  output logic level,
  output logic rise
);
  logic meta; // first stage, read only by the second stage
  logic sync; // second stage
  logic last; // previous synced value for edge finding
  // the edge detector looks only at the second stage and its delayed copy last, to keep metastability out
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= RESET_VALUE;
      sync <= RESET_VALUE;
      last <= RESET_VALUE;
    end
    else if (ce)
    begin
      meta <= pin;
      sync <= meta;
      last <= sync;
    end
  end
  assign level = sync;
  assign rise = ce & sync & ~last;
endmodule

/* File: logic/frame_shifter.sv */
// frame_shifter: collects 32-bit serial frames and flags a complete valid one
// assumes: inputs already synchronised to clk; bit_strobe is one cycle per serial clock rise
`timescale 1ns/1ps
module frame_shifter #(
  parameter int FRAME_BITS = serial_config_pkg::FRAME_BITS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic select_n,
  input wire logic bit_strobe,
  input wire logic bit_value,
  output logic frame_done,
  output logic [3:0] frame_addr,
  output logic [15:0] frame_data
);
  logic [FRAME_BITS-2:0] shift; // bits received so far in this frame
  logic [5:0] count; // index of the bit being received
  logic active; // shifting allowed this cycle
  logic last_bit; // this strobe carries bit 32
  logic [FRAME_BITS-1:0] full; // complete frame including the final bit
  logic header_ok;
  assign active = enable & ~select_n & bit_strobe; // [R1] [R3]
  assign last_bit = (count == serial_config_pkg::COUNT_LAST); // [R4]
  assign full = {shift, bit_value}; // msb arrived first [R4]
  assign header_ok = (full[31:20] == serial_config_pkg::FRAME_HEADER); // [R5] [R22]
  // counter and shift register; select release clears a partial frame
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 6'h00;
      shift <= '0;
    end
    else if (ce)
    begin
      if (select_n || !enable)
      begin
        count <= 6'h00; // partial frame dropped [R22]
      end
      else if (active)
      begin
        shift <= full[FRAME_BITS-2:0];
        count <= last_bit ? 6'h00 : count + 6'h01; // next frame starts at clock 33 [R7]
      end
    end
  end
  // completed frame registered as data outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_done <= 1'b0;
      frame_addr <= 4'h0;
      frame_data <= 16'h0000;
    end
    else if (ce)
    begin
      frame_done <= active & last_bit & header_ok; // [R22]
      if (active && last_bit)
      begin
        frame_addr <= full[19:16]; // address bit three first [R6] [R5]
        frame_data <= full[15:0];
      end
    end
  end
endmodule

/* File: tb/cfg_port_checker_asserts.sv */
// cfg_port_checker: timing relations on the configuration port's pins
// assumes: bound into serial_config_register_port; names match its header
`timescale 1ns/1ps
module cfg_port_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic extended_mode,
  input wire logic power_down,
  input wire logic serial_select_n,
  input wire logic pin_single_rate,
  input wire logic reset_input_differential,
  input wire logic duty_stabilizer_on,
  input wire logic double_rate_strobe_phase,
  input wire logic single_rate_select,
  input wire logic output_edge_rising,
  input wire logic [8:0] offset_value,
  input wire logic [1:0] buffer_size,
  input wire logic auto_stop_write,
  input wire logic test_pattern_on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // six cycles of normal mode leave room for the two-flop mode sync
  a_normal_cfg_default: assert property ((!extended_mode)[*6] |-> !reset_input_differential && duty_stabilizer_on)
    else $error("normal mode config not default");
  a_normal_offset_zero: assert property ((!extended_mode)[*6] |-> offset_value == 9'h000)
    else $error("normal mode offset not zero");
  a_normal_rate_pin: assert property ((!extended_mode)[*6] |-> single_rate_select == pin_single_rate)
    else $error("normal mode rate not from pin");
  a_buffer_default_normal: assert property ((!extended_mode)[*6] |-> buffer_size == 2'h2 && auto_stop_write && !test_pattern_on)
    else $error("normal mode buffer defaults wrong");
  a_ddr_edge_low: assert property (!single_rate_select |-> !output_edge_rising)
    else $error("edge select active in double rate");
  a_sdr_phase_low: assert property (single_rate_select |-> !double_rate_strobe_phase)
    else $error("strobe phase active in single rate");
  // with select idle no frame can finish, so nothing may move
  a_idle_no_update: assert property ((serial_select_n && extended_mode)[*8] |=> $stable({reset_input_differential, duty_stabilizer_on, offset_value, buffer_size}))
    else $error("register changed without a frame");
  a_power_down_keep: assert property ($changed(power_down) |=> $stable({reset_input_differential, single_rate_select, offset_value, buffer_size}))
    else $error("power-down disturbed registers");
endmodule

bind serial_config_register_port cfg_port_checker chk (.*);

/* File: tb/cfg_controller.sv */
// cfg_controller: external controller shifting write frames into the port
// assumes: caller spaces frames; serial clock idles low between frames
// no calibration runs in this bench, so no write ever overlaps one
`timescale 1ns/1ps
module cfg_controller (
  output logic serial_clock,
  output logic serial_select_n,
  output logic serial_input_line
);
  initial
  begin
    serial_clock = 1'b0;
    serial_select_n = 1'b1;
    serial_input_line = 1'b1;
  end
  // shift nbits msb first at a 48 ns period; hold keeps select for a following frame
  task automatic send(input logic [31:0] frame, input int nbits, input bit hold);
    serial_select_n = 1'b0;
    for (int i = 31; i > 31 - nbits; i--)
    begin
      serial_input_line = frame[i];
      #24 serial_clock = 1'b1;
      #24 serial_clock = 1'b0;
    end
    if (!hold)
    begin
      serial_select_n = 1'b1;
      // a released line must not show the stale bit
      serial_input_line = ~serial_input_line;
    end
  endtask
endmodule

/* File: tb/serial_config_register_port_tb.sv */
// serial_config_register_port_tb: frame writes checked against a shadow of the registers
// assumes: cfg_controller drives the serial pins; outputs settle within 12 cycles of a frame
`timescale 1ns/1ps
module serial_config_register_port_tb;
  logic ref_clk, nrst, clk_en, extended_mode, power_down, pin_single_rate, edge_select_pin;
  logic serial_clock, serial_select_n, serial_input_line;
  logic reset_input_differential, termination_trim_skip, duty_stabilizer_on, double_rate_strobe_phase;
  logic single_rate_select, output_edge_rising, offset_negative, phase_adjust_on, low_freq_clock;
  logic auto_stop_write, two_port_enable, test_pattern_on;
  logic [8:0] offset_value, full_scale_adjust, phase_fine;
  logic [3:0] phase_coarse;
  logic [1:0] buffer_size;
  logic [44:0] outs; // all outputs in one vector
  logic [15:0] sh [16]; // shadow of what the registers should hold
  logic [11:0] hdr = serial_config_pkg::FRAME_HEADER;
  logic [3:0] wa [7] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'hE, 4'hF, 4'h1};
  // fixed bits always one; trim skipped before phase adjust is enabled
  logic [15:0] wd [7] = '{16'hE7FF, 16'h12FF, 16'h607F, 16'hFFFF, 16'h8FFF, 16'h5FFF, 16'hBAFF};
  int fails, check_count;
  assign outs = {reset_input_differential, termination_trim_skip, duty_stabilizer_on, double_rate_strobe_phase,
    single_rate_select, output_edge_rising, offset_value, offset_negative, full_scale_adjust, phase_fine,
    phase_adjust_on, phase_coarse, low_freq_clock, buffer_size, auto_stop_write, two_port_enable, test_pattern_on};
  serial_config_register_port uut (.*);
  cfg_controller ctl (.*);
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // power-on contents of the six registers
  task automatic por();
    sh[1] = serial_config_pkg::CONFIG_RESET;
    sh[2] = serial_config_pkg::OFFSET_RESET;
    sh[3] = serial_config_pkg::FULL_SCALE_RESET;
    sh[13] = serial_config_pkg::PHASE_FINE_RESET;
    sh[14] = serial_config_pkg::PHASE_COARSE_RESET;
    sh[15] = serial_config_pkg::CAPTURE_RESET;
  endtask
  // strobe phase only in double rate, output edge only in single rate
  function automatic logic [44:0] exp_vec();
    logic [15:0] c;
    c = sh[1];
    return {c[14], c[13], c[12], c[11] & ~c[10], c[10], c[8] & c[10], 1'b0, sh[2][15:8], sh[2][7],
      sh[3][15:7], sh[13][15:7], sh[14][15], sh[14][14:11], sh[14][10], sh[15][15:11]};
  endfunction
  task automatic check(input logic [44:0] seen, input logic [44:0] exp, input string what);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic look(input string what);
    @(posedge ref_clk);
    #1 check(outs, exp_vec(), what);
  endtask
  // one frame; the shadow follows only whole, well-formed frames to decoded addresses
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [11:0] h, input int n, input bit hold);
    #1.3;
    ctl.send({h, a, d}, n, hold);
    if (n == 32 && h === hdr && extended_mode && a inside {4'h1, 4'h2, 4'h3, 4'hD, 4'hE, 4'hF})
      sh[a] = d;
    if (!hold)
      repeat (12) @(posedge ref_clk);
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    #200000;
    fails++;
    results();
  end
  initial
  begin
    fails = 0;
    check_count = 0;
    clk_en = 1'b1;
    pin_single_rate = 1'b1;
    edge_select_pin = 1'b0;
    extended_mode = 1'b1;
    power_down = 1'b0;
    nrst = 1'b0;
    por();
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    look("power-on values");
    check({39'h0, reset_input_differential, termination_trim_skip, duty_stabilizer_on, double_rate_strobe_phase,
      single_rate_select, output_edge_rising}, 45'h00A, "power-on config fields");
    $display("test power-on done");
    for (int i = 0; i < 7; i++)
    begin
      wr(wa[i], wd[i], hdr, 32, 1'b0); // all six registers written first
      look("field write");
    end
    $display("test field writes done");
    wr(4'h1, 16'hBEFF, hdr, 32, 1'b1);
    wr(4'h2, 16'h807F, hdr, 32, 1'b0);
    look("back-to-back frames");
    wr(4'h4, 16'h0000, hdr, 32, 1'b0);
    look("reserved address");
    wr(4'h1, 16'hA2FF, 12'h002, 32, 1'b0);
    look("bad header");
    wr(4'h1, 16'hA2FF, hdr, 20, 1'b0);
    look("short frame");
    $display("test refused frames done");
    extended_mode <= 1'b0;
    repeat (8) @(posedge ref_clk);
    wr(4'h1, 16'hE7FF, hdr, 32, 1'b0);
    #1 check({36'h0, reset_input_differential, termination_trim_skip, duty_stabilizer_on, single_rate_select,
      buffer_size, auto_stop_write, two_port_enable, test_pattern_on}, 45'h074, "normal mode");
    check({27'h0, double_rate_strobe_phase, output_edge_rising, offset_negative, phase_fine, phase_adjust_on,
      phase_coarse, low_freq_clock}, 45'h0, "normal mode fixed fields");
    check({36'h0, full_scale_adjust}, 45'h100, "normal mode gain");
    // in normal mode rate and output edge follow the pins
    @(posedge ref_clk);
    edge_select_pin <= 1'b1;
    @(posedge ref_clk);
    #1 check({44'h0, output_edge_rising}, 45'h1, "edge pin in single rate");
    @(posedge ref_clk);
    pin_single_rate <= 1'b0;
    @(posedge ref_clk);
    #1 check({43'h0, single_rate_select, output_edge_rising}, 45'h0, "rate pin to double rate");
    @(posedge ref_clk);
    pin_single_rate <= 1'b1;
    edge_select_pin <= 1'b0;
    extended_mode <= 1'b1;
    repeat (8) @(posedge ref_clk);
    look("mode gating");
    power_down <= 1'b1;
    repeat (8) @(posedge ref_clk);
    look("power-down");
    power_down <= 1'b0;
    $display("test modes done");
    nrst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    por();
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    look("second reset");
    $display("test second reset done");
    results();
  end
endmodule
